//--- core/atlm_pkg.sv
package atlm_pkg;

  // ------------------------------------------------------------------
  // clock and delay times
  // ------------------------------------------------------------------
  localparam int ATLM_CLK_HZ       = 50_000_000;
  localparam int ATLM_CYC_PER_MS   = ATLM_CLK_HZ / 1000;
  localparam int ATLM_BFD_SHORT_MS = 100;
  localparam int ATLM_BFD_LONG_MS  = 150;
  localparam int ATLM_PEER_SHORT_MS = 200;
  localparam int ATLM_PEER_LONG_MS  = 300;
  localparam int ATLM_TMR_W        = 24;
  localparam int ATLM_TMR_N        = 4;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0]  ATLM_CFG_OFS  = 8'h00;
  localparam logic [7:0]  ATLM_STAT_OFS = 8'h04;
  localparam logic [31:0] ATLM_CFG_RST  = 32'h0000_0010;
  localparam int ATLM_CFG_SCHEME_LSB = 0;
  localparam int ATLM_CFG_VARIANT_A  = 4;
  localparam int ATLM_CFG_CABLE_LO   = 5;
  localparam int ATLM_CFG_BRK_LO     = 6;
  localparam int ATLM_CFG_BUS_LO     = 7;
  localparam int ATLM_CFG_EXT_LO     = 8;
  localparam int ATLM_CFG_NO_DELAY   = 9;
  localparam int ATLM_CFG_SHORT      = 10;
  localparam int ATLM_CFG_USED_W     = 11;
  localparam int ATLM_STAT_OUT_LSB    = 0;
  localparam int ATLM_STAT_SCHEME_LSB = 9;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic cableLight;
    logic breakerLight;
    logic busLight;
    logic extInputOne;
    logic extInputTwo;
  } atlm_light_t;

  typedef struct packed {
    logic extOvercurrent;
    logic phaseOvercurrent;
    logic residualOvercurrent;
  } atlm_oc_t;

  typedef struct packed {
    logic incomerTrip;
    logic hvSideTrip;
    logic tieTrip;
    logic auxTrip;
    logic feederMasterTrip;
    logic feederOvercurrentOut;
    logic peerOvercurrentOut;
    logic peerLightPulse;
    logic quenchControl;
  } atlm_out_t;

  typedef enum logic [2:0] {
    ATLM_SCHEME_NONE = 3'b001,
    ATLM_SCHEME_ZERO = 3'b010,
    ATLM_SCHEME_ONE  = 3'b100
  } atlm_scheme_t;

endpackage

//--- core/atlm_trip_logic.sv
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module atlm_trip_logic
  import atlm_pkg::*;
#(
  parameter int BFD_SHORT_CYC  = ATLM_BFD_SHORT_MS * ATLM_CYC_PER_MS,
  parameter int BFD_LONG_CYC   = ATLM_BFD_LONG_MS * ATLM_CYC_PER_MS,
  parameter int PEER_SHORT_CYC = ATLM_PEER_SHORT_MS * ATLM_CYC_PER_MS,
  parameter int PEER_LONG_CYC  = ATLM_PEER_LONG_MS * ATLM_CYC_PER_MS
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  atlm_light_t      lightIn,
  input  atlm_oc_t         ocIn,
  output atlm_out_t        tripOut
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  localparam logic [ATLM_TMR_W-1:0] BFD_S  = ATLM_TMR_W'(BFD_SHORT_CYC);
  localparam logic [ATLM_TMR_W-1:0] BFD_L  = ATLM_TMR_W'(BFD_LONG_CYC);
  localparam logic [ATLM_TMR_W-1:0] PEER_S = ATLM_TMR_W'(PEER_SHORT_CYC);
  localparam logic [ATLM_TMR_W-1:0] PEER_L = ATLM_TMR_W'(PEER_LONG_CYC);
  localparam int TMR_CABLE = 0;
  localparam int TMR_HV    = 1;
  localparam int TMR_PEER  = 2;
  localparam int TMR_PCAB  = 3;

  // light passes when channel is light-only or overcurrent is present
  function automatic logic gate_light(input logic light, input logic lightOnly,
                                      input logic anyOc);
    gate_light = light & (lightOnly | anyOc);
  endfunction

  // count saturates at the limit; any drop of the trigger restarts it
  function automatic logic [ATLM_TMR_W-1:0] tmr_next(
    input logic trig, input logic [ATLM_TMR_W-1:0] cnt,
    input logic [ATLM_TMR_W-1:0] limit);
    if (!trig) begin
      tmr_next = '0;
    end else if (cnt >= limit) begin
      tmr_next = cnt;
    end else begin
      tmr_next = cnt + ATLM_TMR_W'(1);
    end
  endfunction

  // ------------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------------
  logic [ATLM_CFG_USED_W-1:0] cfg;
  logic [ATLM_TMR_W-1:0]      tmrCnt [ATLM_TMR_N];
  atlm_scheme_t               schemeSel;

  wire cfgHit    = paddr == ATLM_CFG_OFS;
  wire statHit   = paddr == ATLM_STAT_OFS;
  wire setupPh   = psel && !penable;
  wire accessPh  = psel && penable;
  wire cfgWrite  = accessPh && pwrite && cfgHit;
  wire badAccess = !(cfgHit || statHit) || (pwrite && statHit);

  wire [31:0] cfgWord  = {{(32 - ATLM_CFG_USED_W){1'b0}}, cfg};
  wire [31:0] statWord = {20'h00000, schemeSel, tripOut};
  wire [31:0] next_prdata = (setupPh && !pwrite && cfgHit)  ? cfgWord  :
                            (setupPh && !pwrite && statHit) ? statWord :
                            32'h0000_0000;

  // zero wait states keep the handshake trivial for the master
  assign pready  = 1'b1;
  assign pslverr = accessPh && badAccess;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= ATLM_CFG_RST[ATLM_CFG_USED_W-1:0];
    end else if (cfgWrite) begin
      cfg <= pwdata[ATLM_CFG_USED_W-1:0];
    end
  end

  // read data is captured in setup, so it is a flop during access
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (setupPh) begin
      prdata <= next_prdata;
    end
  end

  // ------------------------------------------------------------------
  // configuration decode
  // ------------------------------------------------------------------
  wire [3:0] schemeCode = cfg[ATLM_CFG_SCHEME_LSB +: 4];
  wire variantA  = cfg[ATLM_CFG_VARIANT_A];
  wire cableLo   = cfg[ATLM_CFG_CABLE_LO];
  wire brkLo     = cfg[ATLM_CFG_BRK_LO];
  wire busLo     = cfg[ATLM_CFG_BUS_LO];
  wire extLo     = cfg[ATLM_CFG_EXT_LO];
  wire noDelay   = cfg[ATLM_CFG_NO_DELAY];
  wire shortTime = cfg[ATLM_CFG_SHORT];

  // other codes leave every output idle
  assign schemeSel = !variantA          ? ATLM_SCHEME_NONE :
                     schemeCode == 4'h0 ? ATLM_SCHEME_ZERO :
                     schemeCode == 4'h1 ? ATLM_SCHEME_ONE  :
                     ATLM_SCHEME_NONE;

  wire schemeOn  = schemeSel != ATLM_SCHEME_NONE;
  wire schemeOne = schemeSel == ATLM_SCHEME_ONE;
  wire schemeZero = schemeSel == ATLM_SCHEME_ZERO;

  wire [ATLM_TMR_W-1:0] bfdLimit  = shortTime ? BFD_S : BFD_L;
  wire [ATLM_TMR_W-1:0] peerLimit = shortTime ? PEER_L : PEER_S;

  // ------------------------------------------------------------------
  // light and overcurrent conditions
  // ------------------------------------------------------------------
  wire anyOc    = ocIn.extOvercurrent | ocIn.phaseOvercurrent
                | ocIn.residualOvercurrent;
  wire extLight = lightIn.extInputOne | lightIn.extInputTwo;
  wire rawNonCable = lightIn.breakerLight | lightIn.busLight | extLight;
  wire gCable   = gate_light(lightIn.cableLight, cableLo, anyOc);
  wire gBrk     = gate_light(lightIn.breakerLight, brkLo, anyOc);
  wire gBus     = gate_light(lightIn.busLight, busLo, anyOc);
  wire gExt     = gate_light(extLight, extLo, anyOc);
  wire gBusExt  = gBus | gExt;

  // ------------------------------------------------------------------
  // delay timers
  // ------------------------------------------------------------------
  logic [ATLM_TMR_N-1:0]  tmrTrig;
  logic [ATLM_TMR_N-1:0]  tmrDone;
  logic [ATLM_TMR_W-1:0]  tmrLimit [ATLM_TMR_N];

  assign tmrTrig[TMR_CABLE] = schemeOn && gCable;
  assign tmrTrig[TMR_HV]    = schemeOn && gBusExt;
  // the peer pulse always waits for external overcurrent
  assign tmrTrig[TMR_PEER]  = schemeOn && (gBrk | gBusExt)
                              && ocIn.extOvercurrent;
  assign tmrTrig[TMR_PCAB]  = schemeOne && gCable
                              && ocIn.extOvercurrent;
  assign tmrLimit[TMR_CABLE] = bfdLimit;
  assign tmrLimit[TMR_HV]    = bfdLimit;
  assign tmrLimit[TMR_PEER]  = bfdLimit;
  assign tmrLimit[TMR_PCAB]  = peerLimit;

  always_comb begin
    for (int i = 0; i < ATLM_TMR_N; i++) begin
      tmrDone[i] = tmrTrig[i] && (tmrCnt[i] >= tmrLimit[i]);
    end
  end

  // reset test kept outermost so the async branch holds constants only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < ATLM_TMR_N; i++) begin
        tmrCnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < ATLM_TMR_N; i++) begin
        tmrCnt[i] <= tmr_next(tmrTrig[i], tmrCnt[i], tmrLimit[i]);
      end
    end
  end

  // ------------------------------------------------------------------
  // trip matrix
  // ------------------------------------------------------------------
  wire instAll = gCable | gBrk | gBusExt;
  wire next_incomer = schemeOn && instAll;
  wire next_aux     = schemeOn && instAll;

  // scheme one keeps the hv side delay even with no-delay selected
  wire hvDelayed = (schemeOne || !noDelay) ? tmrDone[TMR_HV]
                                           : tmrTrig[TMR_HV];
  wire next_hv = schemeOn && (gCable | gBrk | hvDelayed);

  // no-delay removes the cable breaker-failure path altogether
  wire cableLate = !noDelay && tmrDone[TMR_CABLE];
  wire next_tie    = schemeOn && (gBrk | gBusExt | cableLate);
  wire next_master = schemeOn && (gBrk | gBusExt | cableLate);

  wire peerMain = noDelay ? tmrTrig[TMR_PEER] : tmrDone[TMR_PEER];
  wire peerCab  = noDelay ? tmrTrig[TMR_PCAB] : tmrDone[TMR_PCAB];
  // cable only feeds the pulse in scheme one
  wire next_peerPulse = peerMain | peerCab;

  wire next_peerOc = schemeOn && !next_peerPulse
                     && (ocIn.phaseOvercurrent
                         | ocIn.residualOvercurrent);
  wire next_feederOc = schemeOn && anyOc;

  wire quenchZero = schemeZero && (lightIn.cableLight | rawNonCable)
                    && (ocIn.phaseOvercurrent
                        | ocIn.extOvercurrent);
  wire quenchOne  = schemeOne && rawNonCable && anyOc;
  wire next_quench = quenchZero | quenchOne;

  atlm_out_t next_tripOut;

  always_comb begin
    next_tripOut.incomerTrip          = next_incomer;
    next_tripOut.hvSideTrip           = next_hv;
    next_tripOut.tieTrip              = next_tie;
    next_tripOut.auxTrip              = next_aux;
    next_tripOut.feederMasterTrip     = next_master;
    next_tripOut.feederOvercurrentOut = next_feederOc;
    next_tripOut.peerOvercurrentOut   = next_peerOc;
    next_tripOut.peerLightPulse       = next_peerPulse;
    next_tripOut.quenchControl        = next_quench;
  end

  // registered outputs: one clock from input to contact drive
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tripOut <= '0;
    end else begin
      tripOut <= next_tripOut;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  peer_mutex_a: assert property (
    !(tripOut.peerOvercurrentOut && tripOut.peerLightPulse))
    else $error("peer overcurrent and peer pulse together");

  feeder_oc_a: assert property (
    (schemeOn && anyOc) |=> tripOut.feederOvercurrentOut)
    else $error("feeder overcurrent output missing");

  peer_oc_a: assert property (
    (schemeOn && !ocIn.phaseOvercurrent && !ocIn.residualOvercurrent)
    |=> !tripOut.peerOvercurrentOut)
    else $error("peer overcurrent without phase or residual");

  cable_instant_a: assert property (
    (schemeOn && lightIn.cableLight && anyOc)
    |=> (tripOut.incomerTrip && tripOut.hvSideTrip && tripOut.auxTrip))
    else $error("cable light instant trips missing");

  breaker_all_a: assert property (
    (schemeOn && lightIn.breakerLight && brkLo)
    |=> (tripOut.incomerTrip && tripOut.hvSideTrip && tripOut.tieTrip
         && tripOut.auxTrip && tripOut.feederMasterTrip))
    else $error("breaker light trips missing");

  gate_block_a: assert property (
    (!anyOc && !cableLo && !brkLo && !busLo && !extLo)
    |=> !(tripOut.incomerTrip || tripOut.auxTrip))
    else $error("light trip without overcurrent");

  cable_nodelay_a: assert property (
    (noDelay && !lightIn.breakerLight && !lightIn.busLight && !extLight)
    |=> !(tripOut.tieTrip || tripOut.feederMasterTrip))
    else $error("cable delayed trip under no-delay");

  hv_wait_a: assert property (
    (schemeOne && !lightIn.cableLight && !lightIn.breakerLight
     && tmrCnt[TMR_HV] == '0) |=> !tripOut.hvSideTrip)
    else $error("hv side trip without delay");

  peer_ext_a: assert property (
    !ocIn.extOvercurrent |=> !tripOut.peerLightPulse)
    else $error("peer pulse without ext overcurrent");

  quench_zero_a: assert property (
    (schemeZero && !ocIn.phaseOvercurrent && !ocIn.extOvercurrent)
    |=> !tripOut.quenchControl)
    else $error("quench without phase or ext overcurrent");

  quench_one_a: assert property (
    (schemeOne && lightIn.cableLight && !rawNonCable)
    |=> !tripOut.quenchControl)
    else $error("cable light drove quench in scheme one");

  nodelay_peer_a: assert property (
    (schemeOn && noDelay && ocIn.extOvercurrent && lightIn.breakerLight
     && brkLo) |=> tripOut.peerLightPulse)
    else $error("peer pulse not instant under no-delay");

  timer_restart_a: assert property (
    (!tmrTrig[TMR_CABLE] && !noDelay && !gBrk && !gBusExt)
    |=> !tripOut.tieTrip)
    else $error("tie trip after dropped trigger");

  bus_instant_a: assert property (
    (schemeOn && gBusExt)
    |=> (tripOut.incomerTrip && tripOut.tieTrip && tripOut.auxTrip
         && tripOut.feederMasterTrip))
    else $error("bus or ext light instant trips missing");

  hv_bus_wait_a: assert property (
    (schemeZero && !noDelay && !lightIn.cableLight && !lightIn.breakerLight
     && tmrCnt[TMR_HV] == '0) |=> !tripOut.hvSideTrip)
    else $error("hv side trip before breaker-failure delay");

  cable_late_a: assert property (
    (schemeOn && !noDelay && tmrDone[TMR_CABLE])
    |=> (tripOut.tieTrip && tripOut.feederMasterTrip))
    else $error("delayed cable trips missing");

  zero_cable_pulse_a: assert property (
    (schemeZero && !gBrk && !gBusExt) |=> !tripOut.peerLightPulse)
    else $error("cable light drove peer pulse in scheme zero");

  cable_quench_a: assert property (
    (schemeZero && lightIn.cableLight && ocIn.phaseOvercurrent)
    |=> tripOut.quenchControl)
    else $error("cable light did not drive quench in scheme zero");

  peer_cable_wait_a: assert property (
    (schemeOne && !noDelay && !gBrk && !gBusExt
     && tmrCnt[TMR_PCAB] < peerLimit) |=> !tripOut.peerLightPulse)
    else $error("cable peer pulse before its delay");

  cable_peer_fast_a: assert property (
    (schemeOne && noDelay && gCable && ocIn.extOvercurrent)
    |=> tripOut.peerLightPulse)
    else $error("cable peer pulse not instant under no-delay");

  quench_oc_a: assert property (
    (schemeOne && lightIn.breakerLight && ocIn.residualOvercurrent)
    |=> tripOut.quenchControl)
    else $error("quench missing on breaker light with overcurrent");

  scheme_idle_a: assert property (
    !schemeOn |=> tripOut == '0)
    else $error("output active with no scheme selected");

  feeder_quiet_a: assert property (
    !anyOc |=> !tripOut.feederOvercurrentOut)
    else $error("feeder overcurrent output without overcurrent");

  peer_oc_on_a: assert property (
    (schemeOn && ocIn.phaseOvercurrent && !next_peerPulse)
    |=> tripOut.peerOvercurrentOut)
    else $error("peer overcurrent output missing");

  // the incomer trip must drop once the gated light goes; no hidden latching
  breaker_drop_a: assert property (
    (schemeOn && !gCable && !gBrk && !gBusExt && !tmrDone[TMR_HV])
    |=> !tripOut.incomerTrip)
    else $error("incomer trip without light cause");

endmodule // atlm_trip_logic

//--- tb/atlm_field_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// field side: arc sensors and overcurrent relays
// ------------------------------------------------------------------
// levels only; the field is blanked while the relay sits in reset so that
// no stale fault is seen at release
module atlm_field_model
  import atlm_pkg::*;
(
  input  wire logic  reset_n,
  input  atlm_light_t faultReq,
  input  atlm_oc_t    ocReq,
  output atlm_light_t lightIn,
  output atlm_oc_t    ocIn
);
  assign lightIn = reset_n ? faultReq : '0;
  assign ocIn    = reset_n ? ocReq : '0;
endmodule // atlm_field_model

//--- tb/arc_trip_logic_matrix_tb_top.sv
`timescale 1ns/1ps
module arc_trip_logic_matrix_tb_top
  import atlm_pkg::*;
;
  logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  atlm_light_t faultReq, lightIn;
  atlm_oc_t    ocReq, ocIn;
  atlm_out_t   tripOut;
  int          errors, n_compared, cycles;

  // ------------------------------------------------------------------
  // clock, units and timeout
  // ------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // short delays keep the run small: 4/6 breaker-fail, 8/12 peer cable
  atlm_trip_logic #(.BFD_SHORT_CYC(4), .BFD_LONG_CYC(6), .PEER_SHORT_CYC(8),
    .PEER_LONG_CYC(12)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lightIn(lightIn), .ocIn(ocIn), .tripOut(tripOut));

  atlm_field_model field (.reset_n(reset_n), .faultReq(faultReq), .ocReq(ocReq),
    .lightIn(lightIn), .ocIn(ocIn));

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 5000) begin
      errors++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------------
  // compare and bus tasks
  // ------------------------------------------------------------------
  task automatic check_out(input atlm_out_t e);
    n_compared++;
    if (tripOut !== e) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, tripOut);
    end
  endtask

  task automatic check_bus(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // one full transfer; read data and error are taken at the ready edge
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                          input logic [31:0] e, input logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    check_bus({31'h0, err}, {31'h0, pslverr});
    if (!w) check_bus(e, prdata);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // apply a field state, judge it after n edges and 3 more, then clear it
  task automatic step(input atlm_light_t l, input atlm_oc_t o, input int n,
                      input atlm_out_t e1, input atlm_out_t e2);
    @(posedge ref_clk);
    faultReq <= l;
    ocReq    <= o;
    repeat (n) @(posedge ref_clk);
    #1 check_out(e1);
    repeat (3) @(posedge ref_clk);
    #1 check_out(e2);
    @(posedge ref_clk);
    faultReq <= '0;
    ocReq    <= '0;
    repeat (3) @(posedge ref_clk);
    #1 check_out(9'h000);
  endtask

  task automatic report_and_stop();
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    errors = 0; n_compared = 0; cycles = 0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    faultReq = '0; ocReq = '0; reset_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb_xfer(1'b0, ATLM_CFG_OFS, 32'h0, 32'h0000_0010, 1'b0);
    apb_xfer(1'b1, ATLM_STAT_OFS, 32'h0000_0001, 32'h0, 1'b1);
    apb_xfer(1'b0, 8'h08, 32'h0, 32'h0, 1'b1);
    // scheme zero a, breaker light-only, long delay 6
    apb_xfer(1'b1, ATLM_CFG_OFS, 32'h0000_0050, 32'h0, 1'b0);
    step(5'b01000, 3'b000, 2, 9'h1F0, 9'h1F0);
    step(5'b01000, 3'b110, 6, 9'h1FD, 9'h1FB);
    step(5'b00000, 3'b001, 2, 9'h00C, 9'h00C);
    // scheme zero a, every channel gated by overcurrent
    apb_xfer(1'b1, ATLM_CFG_OFS, 32'h0000_0010, 32'h0, 1'b0);
    step(5'b10000, 3'b000, 6, 9'h000, 9'h000);
    step(5'b10000, 3'b010, 6, 9'h1AD, 9'h1FD);
    step(5'b00010, 3'b100, 6, 9'h179, 9'h1FB);
    // scheme zero a without breaker-fail delay
    apb_xfer(1'b1, ATLM_CFG_OFS, 32'h0000_0210, 32'h0, 1'b0);
    step(5'b10000, 3'b010, 6, 9'h1AD, 9'h1AD);
    step(5'b00100, 3'b100, 1, 9'h1FB, 9'h1FB);
    // scheme one a, short time: delay 4, peer cable 12
    apb_xfer(1'b1, ATLM_CFG_OFS, 32'h0000_0411, 32'h0, 1'b0);
    apb_xfer(1'b0, ATLM_STAT_OFS, 32'h0, 32'h0000_0800, 1'b0);
    @(posedge ref_clk);
    faultReq <= 5'b00100;
    ocReq    <= 3'b100;
    repeat (3) @(posedge ref_clk);
    faultReq <= '0;
    step(5'b00100, 3'b100, 4, 9'h179, 9'h1FB);
    step(5'b10000, 3'b100, 12, 9'h1F8, 9'h1FA);
    step(5'b01000, 3'b001, 2, 9'h1FD, 9'h1FD);
    // scheme one a without delay: hv side still waits 6
    apb_xfer(1'b1, ATLM_CFG_OFS, 32'h0000_0211, 32'h0, 1'b0);
    step(5'b00001, 3'b100, 6, 9'h17B, 9'h1FB);
    // codes outside the two schemes drive nothing
    apb_xfer(1'b1, ATLM_CFG_OFS, 32'h0000_0012, 32'h0, 1'b0);
    step(5'b01000, 3'b010, 2, 9'h000, 9'h000);
    apb_xfer(1'b1, ATLM_CFG_OFS, 32'h0000_0000, 32'h0, 1'b0);
    step(5'b01000, 3'b010, 2, 9'h000, 9'h000);
    report_and_stop();
  end
endmodule // arc_trip_logic_matrix_tb_top
